// >>> src/adc_out_pkg.sv
// constants shared by the converter output block
package adc_out_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CAL_CYCLES_FAST = 11528160;
  localparam int CAL_CYCLES_SLOW = 2882040;
  localparam int CAL_W = 24;
  localparam int CONV_TIME_NS = 1600;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int CONV_W = 8;
  localparam int SHIFT_DIV = 4;
  localparam int DIV_W = 2;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h0F;
  localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_CAL = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;
endpackage

// >>> src/word_stream_if.sv
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> src/result_fifo.sv
// synchronous fifo holding conversion results
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  word_stream_if.snk wr,
  word_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign wr.ready = (count != DEPTH[AW:0]);
  assign rd.valid = (count != '0);
  assign rd.data = mem[rd_ptr];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage needs no reset; only counted words are ever read
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= wr.data;
  end
endmodule
`default_nettype wire

// >>> src/adc_serial_out.sv
// calibration status, conversion sequencing and serial result port
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R01 - Calibration-done flag stays low through calibration, high after.
// R02 - Serial result output moves to the next bit on each shift falling edge.
// R03 - The receiver captures each bit on the rising shift clock edge.
// R04 - With the device driving the shift clock, the strobe frames each word.
// R05 - With an external shift clock, the strobe drives an external sample-and-hold for both channels.
// R06 - At the end of a conversion the next channel's track indicator falls.
// R07 - A channel's track indicator rises when its conversion starts.
// R08 - Direction select low makes the shift clock an output at a quarter rate.
// R09 - Release of reset starts a calibration of the full cycle count.
// R10 - Hold falling edges are ignored and no conversion starts in calibration.
// R11 - Channel select is sampled at conversion end to pick the next channel.
// R12 - An idle channel's track indicator stays high, at most one is low.
module adc_serial_out
  import adc_out_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_FAST
) (
  // master clock and reset
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  // shift clock pin, seen as the link clock and driven when self clocked
  input wire logic SHIFT_CLK_IN,
  output logic SHIFT_CLK_OUT,
  output logic SHIFT_CLK_OE_OUT,
  // mode and sampling pins
  input wire logic SHIFT_CLOCK_DIRECTION_SELECT_IN,
  input wire logic HOLD_IN,
  input wire logic CHANNEL_SELECT_IN,
  // result from the converter array, same clock
  input wire logic [WORD_W-1:0] RESULT_IN,
  // status and serial outputs
  output logic CALIBRATION_DONE_FLAG_OUT,
  output logic SERIAL_RESULT_OUT,
  output logic WORD_LATCH_STROBE_OUT,
  output logic TRACK_INDICATOR_A_OUT,
  output logic TRACK_INDICATOR_B_OUT
);
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_CYCLES - 1);
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);

  word_stream_if #(.W(WORD_W)) fill_s ();
  word_stream_if #(.W(WORD_W)) drain_s ();

  result_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(MCLK_IN),
    .rst_n(RESETN_IN),
    .wr(fill_s),
    .rd(drain_s)
  );

  // pin synchronisers
  logic [1:0] hold_sync;
  logic [1:0] chan_sync;
  logic [1:0] dir_sync;
  logic hold_prev;

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      hold_sync <= 2'h3;
      chan_sync <= 2'h0;
      // pin not driven in reset, so an outside clock can reset the link
      dir_sync <= 2'h3;
      hold_prev <= 1'b1;
    end
    else
    begin
      hold_sync <= {hold_sync[0], HOLD_IN};
      chan_sync <= {chan_sync[0], CHANNEL_SELECT_IN};
      dir_sync <= {dir_sync[0], SHIFT_CLOCK_DIRECTION_SELECT_IN};
      hold_prev <= hold_sync[1];
    end
  end

  logic hold_fall;
  logic self_clocked;
  assign hold_fall = hold_prev && !hold_sync[1];
  assign self_clocked = !dir_sync[1];

  // conversion sequencer
  conv_state_t state;
  conv_state_t next_state;
  logic [CAL_W-1:0] cal_cnt;
  logic [CAL_W-1:0] next_cal_cnt;
  logic [CONV_W-1:0] conv_cnt;
  logic [CONV_W-1:0] next_conv_cnt;
  logic acq_chan;
  logic next_acq_chan;
  logic trk_a;
  logic trk_b;
  logic next_trk_a;
  logic next_trk_b;
  logic cal_done;
  logic next_cal_done;
  logic push;
  logic next_push;
  logic [WORD_W-1:0] push_data;
  logic [WORD_W-1:0] next_push_data;

  always_comb
  begin
    next_state = state;
    next_cal_cnt = cal_cnt;
    next_conv_cnt = conv_cnt;
    next_acq_chan = acq_chan;
    next_trk_a = trk_a;
    next_trk_b = trk_b;
    next_cal_done = cal_done;
    next_push = 1'b0;
    next_push_data = push_data;
    case (state)
      ST_CAL:
      begin
        // hold edges fall through unused here  // see R10
        next_cal_cnt = cal_cnt + 1'b1;
        if (cal_cnt == CAL_LAST)  // see R09
        begin
          next_cal_done = 1'b1;  // see R01
          next_state = ST_ACQ;
          next_acq_chan = chan_sync[1];  // see R11
          next_trk_a = chan_sync[1];  // see R06
          next_trk_b = !chan_sync[1];  // see R12
        end
      end
      ST_ACQ:
      begin
        // start only with room to store; a push in the same cycle is not counted, so this result can be dropped
        if (hold_fall && fill_s.ready)
        begin
          next_state = ST_CONV;
          next_conv_cnt = '0;
          next_trk_a = 1'b1;  // see R07
          next_trk_b = 1'b1;  // see R07
        end
      end
      ST_CONV:
      begin
        next_conv_cnt = conv_cnt + 1'b1;
        if (conv_cnt == CONV_LAST)
        begin
          next_state = ST_ACQ;
          next_push = 1'b1;
          next_push_data = RESULT_IN;
          next_acq_chan = chan_sync[1];  // see R11
          next_trk_a = chan_sync[1];  // see R06
          next_trk_b = !chan_sync[1];  // see R12
        end
      end
      default:
      begin
        next_state = ST_CAL;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      state <= ST_CAL;
      cal_cnt <= '0;
      conv_cnt <= '0;
      acq_chan <= 1'b0;
      trk_a <= 1'b1;
      trk_b <= 1'b1;
      cal_done <= 1'b0;
      push <= 1'b0;
      push_data <= RESULT_RESET;
    end
    else
    begin
      state <= next_state;
      cal_cnt <= next_cal_cnt;
      conv_cnt <= next_conv_cnt;
      acq_chan <= next_acq_chan;
      trk_a <= next_trk_a;
      trk_b <= next_trk_b;
      cal_done <= next_cal_done;
      push <= next_push;
      push_data <= next_push_data;
    end
  end

  assign fill_s.valid = push;
  assign fill_s.data = push_data;
  assign CALIBRATION_DONE_FLAG_OUT = cal_done;
  assign TRACK_INDICATOR_A_OUT = trk_a;
  assign TRACK_INDICATOR_B_OUT = trk_b;

  // word hand-off to the link domain by toggle handshake
  logic pending;
  logic next_pending;
  logic req;
  logic next_req;
  logic [WORD_W-1:0] hand_word;
  logic [WORD_W-1:0] next_hand_word;
  logic [1:0] ack_sync;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] next_div;
  logic ack_link;

  assign drain_s.ready = !pending;

  always_comb
  begin
    next_pending = pending;
    next_req = req;
    next_hand_word = hand_word;
    if (pending && (ack_sync[1] == req))
      next_pending = 1'b0;
    if (!pending && drain_s.valid)
    begin
      next_pending = 1'b1;
      next_req = !req;
      next_hand_word = drain_s.data;
    end
    next_div = div + 1'b1;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
    begin
      pending <= 1'b0;
      req <= 1'b0;
      hand_word <= RESULT_RESET;
      ack_sync <= 2'h0;
      div <= '0;
    end
    else
    begin
      pending <= next_pending;
      req <= next_req;
      hand_word <= next_hand_word;
      ack_sync <= {ack_sync[0], ack_link};
      div <= next_div;
    end
  end

  // divider msb toggles every two master cycles: a quarter rate clock
  assign SHIFT_CLK_OUT = div[DIV_W-1];  // see R08
  assign SHIFT_CLK_OE_OUT = self_clocked;  // see R08

  // link domain: shifts on the falling shift clock edge
  logic [1:0] lrst_sync;
  logic [1:0] req_sync;
  logic [WORD_W-1:0] shreg;
  logic [WORD_W-1:0] next_shreg;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [BIT_CNT_W-1:0] next_bit_cnt;
  logic busy;
  logic next_busy;
  logic next_ack_link;
  logic frame;
  logic next_frame;

  always_comb
  begin
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_busy = busy;
    next_ack_link = ack_link;
    next_frame = 1'b0;
    if (busy && bit_cnt != LAST_BIT)
    begin
      next_shreg = {shreg[WORD_W-2:0], 1'b0};  // see R02
      next_bit_cnt = bit_cnt + 1'b1;
    end
    else if (req_sync[1] != ack_link)
    begin
      // last bit done or idle: a waiting word follows back to back
      next_shreg = hand_word;
      next_bit_cnt = '0;
      next_busy = 1'b1;
      next_ack_link = req_sync[1];
      next_frame = 1'b1;  // see R04
    end
    else
    begin
      next_busy = 1'b0;
      next_shreg = '0;
    end
  end

  // receiver samples on the rising edge, half a period after each change
  always_ff @(negedge SHIFT_CLK_IN)  // see R03
  begin
    lrst_sync <= {lrst_sync[0], RESETN_IN};
    if (!lrst_sync[1])
    begin
      req_sync <= 2'h0;
      shreg <= RESULT_RESET;
      bit_cnt <= '0;
      busy <= 1'b0;
      ack_link <= 1'b0;
      frame <= 1'b0;
    end
    else
    begin
      req_sync <= {req_sync[0], req};
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      busy <= next_busy;
      ack_link <= next_ack_link;
      frame <= next_frame;
    end
  end

  assign SERIAL_RESULT_OUT = shreg[WORD_W-1];  // see R02
  // self clocked: word framing; external clock: sample-and-hold control
  assign WORD_LATCH_STROBE_OUT = self_clocked ? frame  // see R04
                                              : (state == ST_CONV);  // see R05
endmodule
`default_nettype wire

// >>> test/adc_serial_out_asserts.sv
// port assertions for the converter output block
`timescale 1ns/1ps
`default_nettype none
module adc_serial_out_asserts
  import adc_out_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_FAST
) (
  // every port of the block, watched only
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic SHIFT_CLK_IN,
  input wire logic SHIFT_CLK_OUT,
  input wire logic SHIFT_CLK_OE_OUT,
  input wire logic SHIFT_CLOCK_DIRECTION_SELECT_IN,
  input wire logic HOLD_IN,
  input wire logic CHANNEL_SELECT_IN,
  input wire logic [WORD_W-1:0] RESULT_IN,
  input wire logic CALIBRATION_DONE_FLAG_OUT,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic WORD_LATCH_STROBE_OUT,
  input wire logic TRACK_INDICATOR_A_OUT,
  input wire logic TRACK_INDICATOR_B_OUT
);
  int cnt;
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  // saturates so the run never wraps it
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESETN_IN)
      cnt <= 0;
    else if (cnt < CAL_CYCLES + 8)
      cnt <= cnt + 1;
  end
  property p_flag_keep;
    $past(CALIBRATION_DONE_FLAG_OUT) |-> CALIBRATION_DONE_FLAG_OUT;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag fell");
  property p_cal_len;
    CALIBRATION_DONE_FLAG_OUT |-> cnt >= CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal short");
  property p_cal_idle;
    !CALIBRATION_DONE_FLAG_OUT |-> TRACK_INDICATOR_A_OUT
      && TRACK_INDICATOR_B_OUT;
  endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("cal track");
  property p_one_low;
    TRACK_INDICATOR_A_OUT || TRACK_INDICATOR_B_OUT;
  endproperty
  a_one_low: assert property (p_one_low) else $error("both low");
  property p_conv_hi;
    $rose(TRACK_INDICATOR_A_OUT && TRACK_INDICATOR_B_OUT) |->
      (TRACK_INDICATOR_A_OUT && TRACK_INDICATOR_B_OUT) [*8];
  endproperty
  a_conv_hi: assert property (p_conv_hi) else $error("conv track");
  property p_dir;
    $stable(SHIFT_CLOCK_DIRECTION_SELECT_IN) [*5] |->
      SHIFT_CLK_OE_OUT != SHIFT_CLOCK_DIRECTION_SELECT_IN;
  endproperty
  a_dir: assert property (p_dir) else $error("clock direction");
  property p_quarter;
    SHIFT_CLK_OE_OUT && $rose(SHIFT_CLK_OUT) |-> ##1 SHIFT_CLK_OUT
      ##1 !SHIFT_CLK_OUT ##1 !SHIFT_CLK_OUT ##1 SHIFT_CLK_OUT;
  endproperty
  a_quarter: assert property (p_quarter) else $error("clock rate");
  property p_fall_only;
    SHIFT_CLK_OE_OUT && $changed(SERIAL_RESULT_OUT) |-> $fell(SHIFT_CLK_IN);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("data edge");
  property p_frame;
    SHIFT_CLK_OE_OUT && $rose(WORD_LATCH_STROBE_OUT) |->
      WORD_LATCH_STROBE_OUT [*4] ##1 !WORD_LATCH_STROBE_OUT;
  endproperty
  a_frame: assert property (p_frame) else $error("frame width");
endmodule
bind adc_serial_out adc_serial_out_asserts #(.CAL_CYCLES(CAL_CYCLES))
  adc_serial_out_asserts_i (.*);
`default_nettype wire

// >>> test/shift_rx_model.sv
// far side: serial receiver and external shift clock source
`timescale 1ns/1ps
`default_nettype none
module shift_rx_model (
  input wire logic sck,
  input wire logic sdo,
  input wire logic run,
  output logic ext_clk,
  output logic [15:0] word,
  output int got
);
  logic [15:0] sh;
  int n;
  initial
  begin
    ext_clk = 1'b0;
    got = 0;
    n = 0;
    sh = 16'h0000;
    word = 16'h0000;
    // stands still low between bursts
    forever #24 ext_clk = run ? ~ext_clk : 1'b0;
  end
  // idle line is low, so a word begins at its set top bit
  always @(posedge sck)
  begin
    if (n > 0 || sdo === 1'b1)
    begin
      sh = {sh[14:0], sdo};
      n = (n + 1) % 16;
      if (n == 0)
      begin
        word = sh;
        got = got + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the converter output block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_out_pkg::*;
  localparam int CAL = 50;
  logic clk, rst_n, dir, hold, sel, run;
  logic [15:0] res, word;
  wire logic sck, sck_out, sck_oe, ext_clk, done, sdo, stb, ta, tb;
  int failures, checks, got;
  assign sck = sck_oe ? sck_out : ext_clk;
  adc_serial_out #(.CAL_CYCLES(CAL)) adc_serial_out_i (
    .MCLK_IN(clk), .RESETN_IN(rst_n), .SHIFT_CLK_IN(sck),
    .SHIFT_CLK_OUT(sck_out), .SHIFT_CLK_OE_OUT(sck_oe),
    .SHIFT_CLOCK_DIRECTION_SELECT_IN(dir), .HOLD_IN(hold),
    .CHANNEL_SELECT_IN(sel), .RESULT_IN(res),
    .CALIBRATION_DONE_FLAG_OUT(done), .SERIAL_RESULT_OUT(sdo),
    .WORD_LATCH_STROBE_OUT(stb), .TRACK_INDICATOR_A_OUT(ta),
    .TRACK_INDICATOR_B_OUT(tb));
  shift_rx_model shift_rx_model_i (.sck(sck), .sdo(sdo), .run(run),
    .ext_clk(ext_clk), .word(word), .got(got));
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input bit c, input string m);
    checks++;
    if (!c)
    begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_got(input int w);
    int i;
    i = 0;
    while (got < w && i < 2000)
    begin
      @(negedge clk);
      i++;
    end
  endtask
  // hold edges during calibration must change nothing
  task automatic cal_seq;
    for (int k = 1; k <= CAL + 4; k++)
    begin
      hold = !((k % 8) < 4 && k < CAL - 8);
      @(negedge clk);
      check(done === (k >= CAL), "done flag");
      check(k >= CAL || (ta & tb) === 1'b1, "track in cal");
    end
    check(ta === 1'b0 && tb === 1'b1, "first acquire");
  endtask
  // second hold fall lands mid-conversion and must be ignored
  task automatic conv(input logic ch, input logic [15:0] d, output bit ok);
    int n;
    sel = ch;
    res = d;
    hold = 1'b0;
    ok = 0;
    n = 0;
    while (!ok && n < 8)
    begin
      @(negedge clk);
      n++;
      ok = (ta & tb) === 1'b1;
    end
    hold = 1'b1;
    check(!ok || !dir || stb === 1'b1, "sample strobe");
    repeat (10) @(negedge clk);
    hold = 1'b0;
    repeat (4) @(negedge clk);
    hold = 1'b1;
    repeat (ok ? 56 : 0) @(negedge clk);
    check(!ok || (ta === ch && tb === !ch), "track at end");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
  end
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
  initial
  begin
    bit ok;
    int acc;
    rst_n = 1'b0;
    dir = 1'b0;
    hold = 1'b1;
    sel = 1'b0;
    run = 1'b1;
    res = 16'h0000;
    acc = 0;
    // link reset needs shift edges, so reset spans a few of them
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    run = 1'b0;
    cal_seq();
    conv(1'b1, 16'hA5C3, ok);
    wait_got(1);
    check(ok && word === 16'hA5C3, "first word");
    conv(1'b0, 16'h8001, ok);
    wait_got(2);
    check(ok && word === 16'h8001 && got == 2, "second word");
    dir = 1'b1;
    repeat (6) @(negedge clk);
    check(sck_oe === 1'b0, "clock direction");
    // stopped link clock fills the buffer until holds are refused
    for (int i = 0; i < 20; i++)
    begin
      conv(i[0], 16'h8000 | 16'(i), ok);
      acc += ok;
    end
    run = 1'b1;
    wait_got(2 + acc);
    check(acc < 20 && got == 2 + acc, "drain count");
    check(word === (16'h8000 | 16'(acc - 1)), "drain last");
    summarize();
  end
endmodule
`default_nettype wire
